/* File: hdl/sfbc_regs.svh */
// register offsets, field positions and reset values
// Notes on behaviour
// - mode register resets to 0x38
// - bit 7 selects msb or lsb first
// - bit 3 guards count writes, reads 1
// - count sets frame length, reads bits left while a frame is busy, else the code
// - count returns to 000 after each frame
// - count cleared by reset and standby
// - control-part reset clears count
// - control-part reset keeps register contents
`ifndef SFBC_REGS_SVH
`define SFBC_REGS_SVH
`define SFBC_ADDR_MODE    4'h0
`define SFBC_ADDR_CTRL    4'h1
`define SFBC_MODE_RESET   8'h38
`define SFBC_BIT_ORDER    7
`define SFBC_BIT_WP       3
`define SFBC_MODE_ONES    8'h38
`define SFBC_CTRL_RST_BIT 1
`define SFBC_CTRL_SYNC    0
`endif

/* File: hdl/sfbc_pkg.sv */
// types shared by the bit counter files
package sfbc_pkg;
  // frame sequencing states
  typedef enum logic [1:0] {
    SFBC_IDLE,
    SFBC_SHIFT,
    SFBC_DONE
  } sfbc_state_t;
endpackage

/* File: hdl/sfbc_sync.sv */
// three-stage synchroniser with edge detection for the link clock
`timescale 1ns/1ps
module sfbc_sync (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // raw pin and results
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic [2:0] stage;  // synchroniser chain
  logic       level;  // filtered level

  // stage 0 is only read by stage 1
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stage <= 3'h0;
      level <= 1'b0;
    end else begin
      stage <= {stage[1:0], pin_in};
      if (stage[1] == stage[2]) begin
        level <= stage[2];
      end
    end
  end

  // edges once stages 1 and 2 agree
  assign level_out = level;
  assign rise_out  = (stage[1] == stage[2]) && stage[2] && !level;
  assign fall_out  = (stage[1] == stage[2]) && !stage[2] && level;
endmodule

/* File: hdl/sfbc_top.sv */
// transfer format and bit count control of the serial interface
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "sfbc_regs.svh"
module sfbc_top (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // register port
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // system
  input  wire logic       standby_in,
  // link
  input  wire logic       scl_in,
  // status to transfer engine
  output logic            lsb_first_out,
  output logic            frame_busy_out,
  output logic            frame_done_out,
  output logic      [3:0] frame_bits_out
);
  logic                 bit_order_select;  // mode bit 7
  logic           [2:0] bit_count;         // count field
  logic                 control_part_reset;// ctrl bit 1
  logic                 sync_mode;         // ctrl bit 0
  logic           [3:0] bits_left;         // bits still to go
  logic           [7:0] rdata;             // read data register
  sfbc_pkg::sfbc_state_t state;            // frame state
  logic                 scl_level;
  logic                 scl_rise;
  logic                 scl_fall;

  // frame length from a count code
  function automatic logic [3:0] frame_len(input logic [2:0] code,
                                           input logic       sync);
    logic [3:0] n;
    n = {1'b0, code};
    if (code == 3'h0) begin
      frame_len = sync ? 4'h8 : 4'h9;
    end else begin
      frame_len = sync ? n : n + 4'h1;
    end
  endfunction

  // link clock sampler
  sfbc_sync u_scl (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .pin_in    (scl_in),
    .level_out (scl_level),
    .rise_out  (scl_rise),
    .fall_out  (scl_fall)
  );

  // register decode
  wire wr_mode    = wr_in && (addr_in == `SFBC_ADDR_MODE);
  wire wr_ctrl    = wr_in && (addr_in == `SFBC_ADDR_CTRL);
  wire count_wr   = wr_mode && !wdata_in[`SFBC_BIT_WP];
  wire seq_clear  = standby_in || control_part_reset;
  wire last_bit   = (state == sfbc_pkg::SFBC_SHIFT) && scl_fall
                    && (bits_left == 4'h1);
  // field read: bits left while busy, else code
  wire [2:0] count_view = (state == sfbc_pkg::SFBC_SHIFT)
                          ? bits_left[2:0] : bit_count;
  wire [7:0] mode_view  = {bit_order_select, 1'b0, 2'b11,
                           1'b1, count_view};
  // control register: sequencing reset and format select
  wire [7:0] ctrl_view  = {6'h00, control_part_reset, sync_mode};
  // unmapped addresses read as zero
  wire [7:0] next_rdata = (addr_in == `SFBC_ADDR_MODE) ? mode_view :
                          (addr_in == `SFBC_ADDR_CTRL) ? ctrl_view :
                          8'h00;

  // software-visible bits; sequencing reset leaves them intact
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_order_select   <= 1'b0;
      control_part_reset <= 1'b0;
      sync_mode          <= 1'b0;
    end else begin
      if (wr_mode) begin
        bit_order_select <= wdata_in[`SFBC_BIT_ORDER];
      end
      if (wr_ctrl) begin
        control_part_reset <= wdata_in[`SFBC_CTRL_RST_BIT];
        sync_mode          <= wdata_in[`SFBC_CTRL_SYNC];
      end
    end
  end

  // count field: clears win, then frame end, then write
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_count <= 3'h0;
    end else if (seq_clear) begin
      bit_count <= 3'h0;
    end else if (last_bit) begin
      bit_count <= 3'h0;
    end else if (count_wr) begin
      bit_count <= wdata_in[2:0];
    end
  end

  // frame sequencer counting link clock falls
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state     <= sfbc_pkg::SFBC_IDLE;
      bits_left <= 4'h0;
    end else if (seq_clear) begin
      state     <= sfbc_pkg::SFBC_IDLE;
      bits_left <= 4'h0;
    end else begin
      case (state)
        sfbc_pkg::SFBC_IDLE: begin
          // a rise starts the frame
          if (scl_rise) begin
            state     <= sfbc_pkg::SFBC_SHIFT;
            bits_left <= frame_len(bit_count, sync_mode);
          end
        end
        sfbc_pkg::SFBC_SHIFT: begin
          // each fall ends one bit
          if (scl_fall) begin
            bits_left <= bits_left - 4'h1;
            if (bits_left == 4'h1) begin
              state <= sfbc_pkg::SFBC_DONE;
            end
          end
        end
        sfbc_pkg::SFBC_DONE: begin
          state <= sfbc_pkg::SFBC_IDLE;
        end
        default: begin
          state <= sfbc_pkg::SFBC_IDLE;
        end
      endcase
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata <= 8'h00;
    end else if (rd_in) begin
      rdata <= next_rdata;
    end
  end

  // outputs
  assign rdata_out      = rdata;
  assign lsb_first_out  = bit_order_select;
  assign frame_busy_out = (state == sfbc_pkg::SFBC_SHIFT);
  assign frame_done_out = (state == sfbc_pkg::SFBC_DONE);
  assign frame_bits_out = bits_left;

  // checks
  a_mode_reset_value: assert property (@(posedge clk_in)
    $rose(rstn_in) |-> mode_view == `SFBC_MODE_RESET)
    else $error("mode register reset value wrong");
  a_wp_blocks_write: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    wr_mode && wdata_in[`SFBC_BIT_WP] && !seq_clear && !last_bit
    |=> $stable(bit_count))
    else $error("protected count changed");
  a_wp_reads_one: assert property (@(posedge clk_in)
    disable iff (!rstn_in) mode_view[`SFBC_BIT_WP])
    else $error("protect bit read zero");
  a_order_follows: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    wr_mode |=> lsb_first_out == $past(wdata_in[`SFBC_BIT_ORDER]))
    else $error("bit order not taken");
  a_frame_end_clear: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    last_bit && !seq_clear |=> bit_count == 3'h0 && frame_done_out)
    else $error("count not cleared at frame end");
  a_clear_count: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    seq_clear |=> bit_count == 3'h0 && !frame_busy_out)
    else $error("sequencing reset missed");
  a_keep_order: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    control_part_reset && !wr_mode |=> $stable(bit_order_select))
    else $error("register lost on sequencing reset");
  a_frame_len: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    state == sfbc_pkg::SFBC_IDLE && scl_rise && !seq_clear
    |=> bits_left == (sync_mode ? ($past(bit_count) == 3'h0 ? 4'h8
        : {1'b0, $past(bit_count)})
        : ($past(bit_count) == 3'h0 ? 4'h9
        : {1'b0, $past(bit_count)} + 4'h1)))
    else $error("frame length wrong");
  a_read_view: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    rd_in |=> rdata_out == $past(next_rdata))
    else $error("read data wrong");
  // register read and count write checks
  a_mode_fixed_bits: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    rd_in && addr_in == `SFBC_ADDR_MODE
    |=> rdata_out[6:3] == 4'h7 && rdata_out[7] == $past(bit_order_select))
    else $error("mode read fixed bits wrong");
  a_wp_allows_write: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    count_wr && !seq_clear && !last_bit
    |=> bit_count == $past(wdata_in[2:0]))
    else $error("unprotected count write lost");
  // frame checks
  a_standby_clear: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    standby_in |=> bit_count == 3'h0 && !frame_busy_out)
    else $error("standby did not clear count");
  a_busy_counts: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    frame_busy_out |-> frame_bits_out != 4'h0)
    else $error("busy frame with no bits left");
  a_done_one_cycle: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    frame_done_out |=> !frame_done_out)
    else $error("frame end pulse too long");

  // scenarios worth seeing
  c_frame_done: cover property (@(posedge clk_in) frame_done_out);
  c_count_write: cover property (@(posedge clk_in) count_wr);
  c_ctrl_reset: cover property (@(posedge clk_in)
    frame_busy_out && control_part_reset);
  c_lsb_frame: cover property (@(posedge clk_in)
    frame_done_out && lsb_first_out);
  c_link_high: cover property (@(posedge clk_in)
    frame_busy_out && scl_level);
endmodule

/* File: verif/sfbc_peer.sv */
// far-side serial peer that clocks frames onto the link clock pin
`timescale 1ns/1ps
module sfbc_peer (
  // link clock driven toward the block
  output logic scl_out
);
  // clock stands low between frames so the host may set a count then
  initial scl_out = 1'b0;
  // one frame of n clock pulses at a 125 ns period
  task automatic send(input int n);
    repeat (n) begin
      #62.5 scl_out = 1'b1;
      #62.5 scl_out = 1'b0;
    end
  endtask
endmodule

/* File: verif/sfbc_top_tb_top.sv */
// self-checking bench for the transfer format and bit count block
`timescale 1ns/1ps
module sfbc_top_tb_top;
  logic       clk_in = 1'b0;     // system clock
  logic       rstn_in = 1'b0;    // active-low reset
  logic [3:0] addr_in = 4'h0;    // register address
  logic [7:0] wdata_in = 8'h00;  // write data
  logic       wr_in = 1'b0;      // write strobe
  logic       rd_in = 1'b0;      // read strobe
  logic       standby_in = 1'b0; // standby request
  logic       scl_in;            // link clock from the peer
  logic [7:0] rdata_out;         // read data
  logic       lsb_first_out;     // bit order to the engine
  logic       frame_busy_out;    // frame in progress
  logic       frame_done_out;    // end-of-frame pulse
  logic [3:0] frame_bits_out;    // bits left in the frame
  int         n_errors = 0;      // mismatches seen
  int         total_checks = 0;  // comparisons made
  int         cycles = 0;        // watchdog count
  int         c;                 // frame table index
  // device under test
  sfbc_top dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .standby_in(standby_in), .scl_in(scl_in),
    .lsb_first_out(lsb_first_out), .frame_busy_out(frame_busy_out),
    .frame_done_out(frame_done_out), .frame_bits_out(frame_bits_out));
  // far-side peer
  sfbc_peer peer_u (.scl_out(scl_in));
  // 100 MHz clock
  initial forever #5 clk_in = ~clk_in;
  // closing report
  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog cuts a hang short
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      results();
    end
  end
  // compare seen against expected
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 check("rdata", rdata_out, exp);
  endtask
  // set format and count, run one frame, confirm length and auto clear
  task automatic frame(input logic [7:0] mode, input logic sync_sel,
                       input logic [3:0] nbits);
    int i;
    wr(4'h1, {7'h00, sync_sel});
    wr(4'h0, mode);
    #1 check("order", {7'h00, lsb_first_out}, {7'h00, mode[7]});
    fork
      peer_u.send(nbits);
      begin
        i = 0;
        while (frame_busy_out !== 1'b1 && i < 60) begin
          @(posedge clk_in);
          #1 i++;
        end
        check("bits", {4'h0, frame_bits_out}, {4'h0, nbits});
        rd(4'h0, {mode[7], 4'h7, nbits[2:0]});
        while (frame_done_out !== 1'b1 && i < 400) begin
          @(posedge clk_in);
          #1 i++;
        end
        check("done", {7'h00, frame_done_out}, 8'h01);
      end
    join
    rd(4'h0, {mode[7], 7'h38});
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(4'h0, 8'h38);
    wr(4'h0, 8'h0D);
    rd(4'h0, 8'h38);
    wr(4'h0, 8'h05);
    rd(4'h0, 8'h3D);
    rd(4'h7, 8'h00);
    wr(4'h7, 8'hFF);
    rd(4'h0, 8'h3D);
    for (c = 0; c < 8; c++) begin
      frame({5'h00, c[2:0]}, 1'b0, (c == 0) ? 4'h9 : 4'(c + 1));
      frame({5'h10, c[2:0]}, 1'b1, (c == 0) ? 4'h8 : 4'(c));
    end
    wr(4'h0, 8'h03);
    wr(4'h1, 8'h00);
    @(posedge clk_in);
    standby_in <= 1'b1;
    @(posedge clk_in);
    standby_in <= 1'b0;
    rd(4'h0, 8'h38);
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h83);
    wr(4'h1, 8'h03);
    rd(4'h0, 8'hB8);
    rd(4'h1, 8'h03);
    peer_u.send(3);
    check("busy", {7'h00, frame_busy_out}, 8'h00);
    wr(4'h1, 8'h01);
    rd(4'h0, 8'hB8);
    results();
  end
endmodule
